// ### dv/pim_core_bench.sv
`timescale 1ns/1ps
module pim_core_bench;
  logic       clk;
  logic       srst;
  logic [7:0] req;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       ack;
  logic [7:0] rdata;
  logic [7:0] ack_data;
  logic       intr;
  logic [7:0] d;
  logic [23:0] b;
  int         n_errors = 0;
  int         check_count = 0;

  pim_core i_pim_core (
    .I_CLOCK(clk), .I_SRST(srst), .I_REQ(req), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .I_ACK(ack), .O_RDATA(rdata), .O_ACK_DATA(ack_data),
    .O_INT(intr)
  );

  pim_host_model i_pim_host_model (
    .i_clk(clk), .i_rdata(rdata), .i_ack_data(ack_data), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .o_ack(ack)
  );

  initial clk = 1'h0;
  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // interrupt output settles a few cycles after its cause
  task automatic chk_int(input logic exp);
    repeat (4) @(posedge clk);
    #1;
    // look after the edge so a value launched by that edge is never missed
    for (int i = 0; i < 4 && intr !== exp; i++) begin
      @(posedge clk);
      #1;
    end
    check_count++;
    if (intr !== exp) begin
      n_errors++;
      $display("CHECK FAILED interrupt expected %h seen %h", exp, intr);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    i_pim_host_model.write_reg(a, v);
  endtask

  task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
    i_pim_host_model.read_reg(a, d);
    chk8(name, exp, d);
  endtask

  task automatic ack_chk(input int n, input logic [23:0] exp);
    i_pim_host_model.ack_cycle(n, b);
    for (int i = 0; i < n; i++) chk8("ack byte", exp[i*8+:8], b[i*8+:8]);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    n_errors++;
    final_report();
  end

  initial begin
    srst = 1'h1;
    req  = 8'h00;
    repeat (4) @(posedge clk);
    srst <= 1'h0;
    rd_chk("mask", pim_pkg::OFS_MASK, pim_pkg::MASK_RESET);
    rd_chk("status", pim_pkg::OFS_END_ROTATE, {5'h0, pim_pkg::PTR_RESET});
    rd_chk("unmapped", 4'h9, 8'h00);
    wr_reg(pim_pkg::OFS_VECTOR_BASE, 8'h40);
    wr_reg(pim_pkg::OFS_CALL_HIGH, 8'h12);
    // fully nested, call mode
    req <= 8'h28;
    chk_int(1'h1);
    ack_chk(3, {8'h12, 8'h43, pim_pkg::CALL_OPCODE});
    rd_chk("isr", pim_pkg::OFS_MODE, 8'h08);
    chk_int(1'h0);
    req <= 8'h2a;
    chk_int(1'h1);
    wr_reg(pim_pkg::OFS_MASK, 8'h02);
    chk_int(1'h0);
    wr_reg(pim_pkg::OFS_MASK, 8'h00);
    req <= 8'h28;
    wr_reg(pim_pkg::OFS_END_ROTATE, 8'h20);
    rd_chk("isr", pim_pkg::OFS_MODE, 8'h00);
    // polling and rotation commands
    wr_reg(pim_pkg::OFS_MODE, 8'h04);
    // a higher request arriving after the poll write must not reach the poll byte
    req <= 8'h2a;
    chk_int(1'h0);
    rd_chk("poll", pim_pkg::OFS_PENDING, 8'h83);
    req <= 8'h28;
    rd_chk("isr", pim_pkg::OFS_MODE, 8'h08);
    wr_reg(pim_pkg::OFS_END_ROTATE, 8'h63);
    rd_chk("isr", pim_pkg::OFS_MODE, 8'h00);
    wr_reg(pim_pkg::OFS_END_ROTATE, 8'hc4);
    rd_chk("status", pim_pkg::OFS_END_ROTATE, 8'h04);
    wr_reg(pim_pkg::OFS_MODE, 8'h04);
    rd_chk("poll", pim_pkg::OFS_MASK, 8'h85);
    wr_reg(pim_pkg::OFS_END_ROTATE, 8'he5);
    rd_chk("isr", pim_pkg::OFS_MODE, 8'h00);
    rd_chk("status", pim_pkg::OFS_END_ROTATE, 8'h05);
    wr_reg(pim_pkg::OFS_MODE, 8'h04);
    rd_chk("poll", pim_pkg::OFS_MODE, 8'h83);
    wr_reg(pim_pkg::OFS_END_ROTATE, 8'ha0);
    rd_chk("isr", pim_pkg::OFS_MODE, 8'h00);
    rd_chk("status", pim_pkg::OFS_END_ROTATE, 8'h03);
    req <= 8'h00;
    repeat (2) @(posedge clk);
    wr_reg(pim_pkg::OFS_MODE, 8'h04);
    rd_chk("poll idle", pim_pkg::OFS_MODE, 8'h07);
    // vector mode with automatic end and rotation
    wr_reg(pim_pkg::OFS_INIT, 8'h03);
    rd_chk("init", pim_pkg::OFS_INIT, 8'h06);
    wr_reg(pim_pkg::OFS_END_ROTATE, 8'h80);
    rd_chk("status", pim_pkg::OFS_END_ROTATE, 8'h47);
    req <= 8'h04;
    chk_int(1'h1);
    ack_chk(2, {8'h00, 8'h42, 8'h00});
    rd_chk("isr", pim_pkg::OFS_MODE, 8'h00);
    rd_chk("status", pim_pkg::OFS_END_ROTATE, 8'h42);
    wr_reg(pim_pkg::OFS_END_ROTATE, 8'h20);
    rd_chk("status", pim_pkg::OFS_END_ROTATE, 8'h02);
    req <= 8'h00;
    // special mask mode
    wr_reg(pim_pkg::OFS_INIT, 8'h00);
    req <= 8'h08;
    chk_int(1'h1);
    ack_chk(3, {8'h12, 8'h43, pim_pkg::CALL_OPCODE});
    i_pim_host_model.enter_special_mask();
    rd_chk("status", pim_pkg::OFS_END_ROTATE, 8'h87);
    req <= 8'h28;
    chk_int(1'h1);
    wr_reg(pim_pkg::OFS_MODE, 8'h20);
    rd_chk("status", pim_pkg::OFS_END_ROTATE, 8'h87);
    wr_reg(pim_pkg::OFS_MODE, 8'h40);
    rd_chk("status", pim_pkg::OFS_END_ROTATE, 8'h07);
    chk_int(1'h0);
    wr_reg(pim_pkg::OFS_END_ROTATE, 8'h63);
    rd_chk("isr", pim_pkg::OFS_MODE, 8'h00);
    req <= 8'h00;
    // slave input lock-out versus special nesting
    for (int nest = 0; nest < 2; nest++) begin
      wr_reg(pim_pkg::OFS_INIT, (nest == 1) ? 8'h04 : 8'h00);
      wr_reg(pim_pkg::OFS_SLAVE_MAP, 8'h02);
      req <= 8'h02;
      chk_int(1'h1);
      ack_chk(3, {8'h12, 8'h41, pim_pkg::CALL_OPCODE});
      chk_int(nest == 1);
      req <= 8'h00;
      wr_reg(pim_pkg::OFS_END_ROTATE, 8'h20);
      rd_chk("isr", pim_pkg::OFS_MODE, 8'h00);
    end
    final_report();
  end
endmodule

// ### dv/pim_host_model.sv
`timescale 1ns/1ps
module pim_host_model (
  input  wire logic                  i_clk,      // bus clock
  input  wire logic [7:0]            i_rdata,    // read data
  input  wire logic [7:0]            i_ack_data, // acknowledge byte
  output logic [pim_pkg::ADDR_W-1:0] o_addr,     // register address
  output logic [7:0]                 o_wdata,    // write data
  output logic                       o_wr,       // write strobe
  output logic                       o_rd,       // read strobe
  output logic                       o_ack       // acknowledge strobe
);
  initial begin
    o_addr  = 4'h0;
    o_wdata = 8'h00;
    o_wr    = 1'h0;
    o_rd    = 1'h0;
    o_ack   = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // released address and data are inverted so a stale value is never trusted
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'h1;
    @(posedge i_clk);
    o_wr    <= 1'h0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask

  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'h1;
    @(posedge i_clk);
    o_rd   <= 1'h0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask

  task automatic ack_pulse(output logic [7:0] d);
    @(posedge i_clk);
    o_ack <= 1'h1;
    @(posedge i_clk);
    o_ack <= 1'h0;
    #1;
    d = i_ack_data;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // pulse count must match the configured system mode
  task automatic ack_cycle(input int n, output logic [23:0] bytes);
    logic [7:0] d;
    bytes = 24'h0;
    for (int i = 0; i < n; i++) begin
      ack_pulse(d);
      bytes[i*8+:8] = d;
    end
  endtask

  // in-service copied into the mask before the mode switch
  task automatic enter_special_mask();
    logic [7:0] d;
    read_reg(pim_pkg::OFS_MODE, d);
    write_reg(pim_pkg::OFS_MASK, d);
    write_reg(pim_pkg::OFS_MODE, 8'h60);
  endtask
endmodule

// ### hdl/pim_ack_seq.sv
`timescale 1ns/1ps
module pim_ack_seq (
  input  wire logic       i_clk,          // clock
  input  wire logic       i_srst,         // sync reset
  input  wire logic       i_ack,          // acknowledge pulse
  input  wire logic       i_vector_mode,  // two pulses when set
  output logic [1:0]      o_step,         // index of the current pulse
  output logic            o_last          // current pulse ends the cycle
);

  logic [1:0] step_q;

  assign o_step = step_q;
  assign o_last = (step_q == (i_vector_mode ? pim_pkg::VECTOR_LAST_STEP
                                            : pim_pkg::CALL_LAST_STEP));

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      step_q <= 2'h0;
    end else if (i_ack) begin
      step_q <= o_last ? 2'h0 : step_q + 2'h1;
    end
  end

  a_step_bound: assert property (@(posedge i_clk) disable iff (i_srst)
    i_vector_mode |-> step_q <= pim_pkg::VECTOR_LAST_STEP)
    else $error("two-pulse cycle ran past its second pulse");

endmodule

// ### hdl/pim_core.sv
`timescale 1ns/1ps
// Functional notes
// - special mask: only mask bits block levels
// - after init, level 0 highest, 7 lowest
// - acknowledge picks winner, sets in-service, drives data
// - end command or auto mode clears in-service
// - in-service blocks equal and lower, not higher
// - plain nesting locks out an in-service slave input
// - special nesting re-accepts an in-service slave input
// - poll mode keeps interrupt output low
// - first read after poll acts as acknowledge
// - poll byte carries level code and pending flag
// - requests frozen from poll write to read
// - automatic rotation puts serviced level lowest
// - rotate non-specific end clears highest, rotates it
// - rotate alone arms rotation under automatic end
// - set priority makes selected level lowest
// - rotate specific end clears level, makes it lowest
// - three pulses in call, two in vector
// - each mask bit blocks only its own input
// - special mask left only by init or by a mode word with write enable set
// - end command, non-specific or specific by level bit
module pim_core (
  input  wire logic                         I_CLOCK,    // 125 MHz clock
  input  wire logic                         I_SRST,     // sync reset, active high
  input  wire logic [7:0]                   I_REQ,      // request inputs, level
  input  wire logic [pim_pkg::ADDR_W-1:0]   I_ADDR,     // register address
  input  wire logic [7:0]                   I_WDATA,    // write data
  input  wire logic                         I_WR,       // write strobe
  input  wire logic                         I_RD,       // read strobe
  input  wire logic                         I_ACK,      // acknowledge strobe
  output logic [7:0]                        O_RDATA,    // read data, cycle after strobe
  output logic [7:0]                        O_ACK_DATA, // byte for the acknowledge pulse
  output logic                              O_INT       // interrupt request to CPU
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  pim_pkg::pim_cfg_s cfg_q;
  pim_pkg::pim_erc_s erc;
  logic [7:0]        slave_map_q;
  logic [7:0]        mask_q;
  logic [7:0]        isr_q;
  logic [7:0]        req_q;
  logic [7:0]        vec_base_q;
  logic [7:0]        call_high_q;
  logic [2:0]        ptr_q;
  logic              smm_q;
  logic              rot_automatic_end_of_service_q;
  logic              poll_q;
  logic [2:0]        ack_lvl_q;
  logic              ack_real_q;
  logic [7:0]        rdata_q;
  logic [7:0]        ack_data_q;
  logic              int_q;

  logic       init_wr, erc_wr, mode_wr, poll_rd;
  logic [1:0] ack_step;
  logic       ack_last, ack_first;
  logic [7:0] pend, isr_eff;
  logic       win_found, isr_found;
  logic [2:0] win_lvl, isr_lvl;
  logic       int_ok;
  logic       take;
  logic [2:0] take_lvl;
  logic [7:0] isr_set, isr_clr;
  logic       automatic_end_of_service_done;

  assign init_wr   = I_WR && (I_ADDR == pim_pkg::OFS_INIT);
  assign erc_wr    = I_WR && (I_ADDR == pim_pkg::OFS_END_ROTATE);
  assign mode_wr   = I_WR && (I_ADDR == pim_pkg::OFS_MODE);
  assign poll_rd   = I_RD && poll_q;
  assign erc       = {I_WDATA[pim_pkg::ERC_ROTATE_POS], I_WDATA[pim_pkg::ERC_SPEC_POS],
                      I_WDATA[pim_pkg::ERC_EOS_POS], I_WDATA[2:0]};
  assign ack_first = I_ACK && (ack_step == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // priority resolution

  assign pend    = req_q & ~mask_q;
  assign isr_eff = smm_q ? 8'h00 : isr_q;

  pim_resolver #(.N(pim_pkg::NUM_LEVELS)) u_req_res (
    .i_vec   (pend),
    .i_ptr   (ptr_q),
    .o_found (win_found),
    .o_level (win_lvl)
  );

  pim_resolver #(.N(pim_pkg::NUM_LEVELS)) u_isr_res (
    .i_vec   (isr_q),
    .i_ptr   (ptr_q),
    .o_found (isr_found),
    .o_level (isr_lvl)
  );

  // highest in-service level that still blocks, honouring special mask
  logic       blk_found;
  logic [2:0] blk_lvl;
  pim_resolver #(.N(pim_pkg::NUM_LEVELS)) u_blk_res (
    .i_vec   (isr_eff),
    .i_ptr   (ptr_q),
    .o_found (blk_found),
    .o_level (blk_lvl)
  );

  always_comb begin
    int_ok = 1'b0;
    if (win_found) begin
      if (!blk_found) begin
        int_ok = 1'b1;
      end else if (pim_pkg::rank(win_lvl, ptr_q) < pim_pkg::rank(blk_lvl, ptr_q)) begin
        int_ok = 1'b1;
      end else if (win_lvl == blk_lvl && slave_map_q[win_lvl]) begin
        int_ok = cfg_q.special_nesting;
      end
    end
  end

  // an acknowledge or a poll read takes the winner; nothing eligible reads as 7
  assign take     = (ack_first || poll_rd) && int_ok;
  assign take_lvl = int_ok ? win_lvl : 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge sequencing

  pim_ack_seq u_ack (
    .i_clk         (I_CLOCK),
    .i_srst        (I_SRST || init_wr),
    .i_ack         (I_ACK),
    .i_vector_mode (cfg_q.vector_mode),
    .o_step        (ack_step),
    .o_last        (ack_last)
  );

  assign automatic_end_of_service_done = I_ACK && ack_last && cfg_q.auto_eos && ack_real_q;

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      ack_lvl_q  <= 3'h0;
      ack_real_q <= 1'b0;
    end else if (ack_first) begin
      ack_lvl_q  <= take_lvl;
      ack_real_q <= int_ok;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      ack_data_q <= 8'h00;
    end else if (I_ACK) begin
      unique case (ack_step)
        2'h0:    ack_data_q <= cfg_q.vector_mode ? 8'h00 : pim_pkg::CALL_OPCODE;
        2'h1:    ack_data_q <= {vec_base_q[7:3], ack_lvl_q};
        default: ack_data_q <= call_high_q;
      endcase
    end else begin
      ack_data_q <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // in-service bits: a set from an acknowledge wins over any end-of-service clear

  always_comb begin
    isr_set = 8'h00;
    isr_clr = 8'h00;
    if (take) begin
      isr_set[take_lvl] = 1'b1;
    end
    if (automatic_end_of_service_done) begin
      isr_clr[ack_lvl_q] = 1'b1;
    end
    if (erc_wr && erc.eos) begin
      if (erc.specific) begin
        isr_clr[erc.level] = 1'b1;
      end else if (isr_found) begin
        isr_clr[isr_lvl] = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST || init_wr) begin
      isr_q <= 8'h00;
    end else begin
      isr_q <= (isr_q & ~isr_clr) | isr_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rotation pointer and rotate-under-auto flag

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST || init_wr) begin
      ptr_q <= pim_pkg::PTR_RESET;
    end else if (erc_wr && erc.rotate && erc.specific) begin
      ptr_q <= erc.level;
    end else if (erc_wr && erc.rotate && erc.eos && isr_found) begin
      ptr_q <= isr_lvl;
    end else if (automatic_end_of_service_done && rot_automatic_end_of_service_q) begin
      ptr_q <= ack_lvl_q;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST || init_wr) begin
      rot_automatic_end_of_service_q <= 1'b0;
    end else if (erc_wr && !erc.specific && erc.rotate && !erc.eos) begin
      rot_automatic_end_of_service_q <= 1'b1;
    end else if (erc_wr && !erc.specific && !erc.rotate && erc.eos) begin
      rot_automatic_end_of_service_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      cfg_q       <= '0;
      slave_map_q <= 8'h00;
      vec_base_q  <= 8'h00;
      call_high_q <= 8'h00;
    end else if (I_WR) begin
      if (init_wr) begin
        cfg_q <= {I_WDATA[pim_pkg::INIT_VECTOR_POS], I_WDATA[pim_pkg::INIT_AUTO_POS],
                  I_WDATA[pim_pkg::INIT_NEST_POS]};
      end
      if (I_ADDR == pim_pkg::OFS_SLAVE_MAP) begin
        slave_map_q <= I_WDATA;
      end
      if (I_ADDR == pim_pkg::OFS_VECTOR_BASE) begin
        vec_base_q <= I_WDATA;
      end
      if (I_ADDR == pim_pkg::OFS_CALL_HIGH) begin
        call_high_q <= I_WDATA;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST || init_wr) begin
      mask_q <= pim_pkg::MASK_RESET;
    end else if (I_WR && I_ADDR == pim_pkg::OFS_MASK) begin
      mask_q <= I_WDATA;
    end
  end

  // special mask and poll arming from the mode command word
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST || init_wr) begin
      smm_q <= 1'b0;
    end else if (mode_wr && I_WDATA[pim_pkg::MODE_SPECIAL_MASK_WRITE_ENABLE_POS]) begin
      smm_q <= I_WDATA[pim_pkg::MODE_SMM_POS];
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST || init_wr) begin
      poll_q <= 1'b0;
    end else if (mode_wr && I_WDATA[pim_pkg::MODE_POLL_POS]) begin
      poll_q <= 1'b1;
    end else if (I_RD) begin
      poll_q <= 1'b0;
    end
  end

  // requests sampled each cycle, held still while a poll is outstanding
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      req_q <= 8'h00;
    end else if (!poll_q && !(mode_wr && I_WDATA[pim_pkg::MODE_POLL_POS])) begin
      req_q <= I_REQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port and interrupt output

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      rdata_q <= 8'h00;
    end else if (poll_rd) begin
      rdata_q <= {int_ok, 4'h0, take_lvl};
    end else if (I_RD) begin
      unique case (I_ADDR)
        pim_pkg::OFS_INIT:        rdata_q <= {5'h00, cfg_q};
        pim_pkg::OFS_SLAVE_MAP:   rdata_q <= slave_map_q;
        pim_pkg::OFS_MASK:        rdata_q <= mask_q;
        pim_pkg::OFS_END_ROTATE:  rdata_q <= {smm_q, rot_automatic_end_of_service_q, poll_q, 2'h0, ptr_q};
        pim_pkg::OFS_MODE:        rdata_q <= isr_q;
        pim_pkg::OFS_PENDING:     rdata_q <= req_q;
        pim_pkg::OFS_VECTOR_BASE: rdata_q <= vec_base_q;
        pim_pkg::OFS_CALL_HIGH:   rdata_q <= call_high_q;
        default:                  rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // request drops while an acknowledge cycle is running so it is not re-raised
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST || init_wr) begin
      int_q <= 1'b0;
    end else begin
      int_q <= int_ok && !poll_q && !I_ACK && ack_step == 2'h0;
    end
  end

  assign O_RDATA    = rdata_q;
  assign O_ACK_DATA = ack_data_q;
  assign O_INT      = int_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_ack_sets_isr: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    ack_first && int_ok && !init_wr |=> isr_q[$past(win_lvl)])
    else $error("acknowledged level not marked in service");

  a_init_lowest: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    init_wr |=> ptr_q == 3'h7 && isr_q == 8'h00)
    else $error("init did not restore default nesting");

  a_nonspec_end: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    erc_wr && erc.eos && !erc.specific && isr_found && !take
    |=> !isr_q[$past(isr_lvl)])
    else $error("non-specific end left top in-service bit set");

  a_rot_end: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    erc_wr && erc.rotate && erc.eos && !erc.specific && isr_found
    |=> ptr_q == $past(isr_lvl))
    else $error("rotate on end did not move ended level lowest");

  a_set_prio: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    erc_wr && erc.rotate && erc.specific && !erc.eos |=> ptr_q == $past(I_WDATA[2:0]))
    else $error("set priority did not load lowest level");

  a_spec_rot: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    erc_wr && erc.rotate && erc.specific && erc.eos && !take
    |=> ptr_q == $past(erc.level) && !isr_q[$past(erc.level)])
    else $error("specific rotate end failed");

  a_poll_int_off: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    poll_q |=> !int_q)
    else $error("interrupt raised while poll outstanding");

  a_poll_byte: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    poll_rd |=> O_RDATA[7] == $past(int_ok) && O_RDATA[6:3] == 4'h0
               && O_RDATA[2:0] == $past(take_lvl))
    else $error("poll byte wrong");

  a_poll_freeze: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    poll_q ##1 poll_q |-> $stable(req_q))
    else $error("requests moved during poll");

  a_smm_hold: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    mode_wr && !I_WDATA[pim_pkg::MODE_SPECIAL_MASK_WRITE_ENABLE_POS] && !init_wr |=> $stable(smm_q))
    else $error("special mask changed without write enable");

  a_mask_blocks: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    int_q |-> $past(win_found) && !$past(mask_q[win_lvl]))
    else $error("interrupt raised for a masked level");

endmodule

// ### hdl/pim_pkg.sv
package pim_pkg;

  localparam int          ADDR_W          = 4;
  localparam int          NUM_LEVELS      = 8;

  // register offsets
  localparam logic [3:0]  OFS_INIT        = 4'h0;
  localparam logic [3:0]  OFS_SLAVE_MAP   = 4'h1;
  localparam logic [3:0]  OFS_MASK        = 4'h2;
  localparam logic [3:0]  OFS_END_ROTATE  = 4'h3;
  localparam logic [3:0]  OFS_MODE        = 4'h4;
  localparam logic [3:0]  OFS_PENDING     = 4'h5;
  localparam logic [3:0]  OFS_VECTOR_BASE = 4'h6;
  localparam logic [3:0]  OFS_CALL_HIGH   = 4'h7;

  // init word fields
  localparam int          INIT_VECTOR_POS = 0;
  localparam int          INIT_AUTO_POS   = 1;
  localparam int          INIT_NEST_POS   = 2;

  // mode command word fields
  localparam int          MODE_SPECIAL_MASK_WRITE_ENABLE_POS   = 6;
  localparam int          MODE_SMM_POS    = 5;
  localparam int          MODE_POLL_POS   = 2;

  // end/rotate command word fields
  localparam int          ERC_ROTATE_POS  = 7;
  localparam int          ERC_SPEC_POS    = 6;
  localparam int          ERC_EOS_POS     = 5;

  // poll byte fields
  localparam int          POLL_FLAG_POS   = 7;

  // status byte fields at the end/rotate offset
  localparam int          STAT_SMM_POS    = 7;
  localparam int          STAT_ROT_POS    = 6;
  localparam int          STAT_POLL_POS   = 5;

  localparam logic [2:0]  PTR_RESET       = 3'h7;
  localparam logic [7:0]  MASK_RESET      = 8'h00;
  localparam logic [7:0]  CALL_OPCODE     = 8'hcd;
  localparam logic [1:0]  CALL_LAST_STEP  = 2'h2;
  localparam logic [1:0]  VECTOR_LAST_STEP = 2'h1;

  typedef struct packed {
    logic       rotate;
    logic       specific;
    logic       eos;
    logic [2:0] level;
  } pim_erc_s;

  typedef struct packed {
    logic vector_mode;
    logic auto_eos;
    logic special_nesting;
  } pim_cfg_s;

  // 0 is the highest rank; the level just above the lowest pointer ranks first
  function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] ptr);
    rank = lvl - ptr - 3'h1;
  endfunction

endpackage

// ### hdl/pim_resolver.sv
`timescale 1ns/1ps
module pim_resolver #(
  parameter int N = 8
) (
  input  wire logic [N-1:0] i_vec,    // candidate bits
  input  wire logic [2:0]   i_ptr,    // lowest-priority level
  output logic              o_found,  // any bit set
  output logic [2:0]        o_level   // highest-ranked set level
);

  // walk from lowest rank to highest so the best candidate is written last
  always_comb begin
    logic [2:0] idx;
    idx     = '0;
    o_found = |i_vec;
    o_level = '0;
    for (int i = N; i >= 1; i--) begin
      idx = i_ptr + i[2:0];
      if (i_vec[idx]) begin
        o_level = idx;
      end
    end
  end

endmodule
